//--- common/twb_defs.vh
// Purpose: Constants for the tape word buffer control block
// Assumes: 125 MHz system clock, 32-bit classic Wishbone register port
// Notes:   Offsets are byte addresses of aligned 32-bit words
`ifndef TWB_DEFS_VH
`define TWB_DEFS_VH

////////////////////////////////////////////////////////////////////////////////
// Register map
`define TWB_CTRL_OFS        4'h0
`define TWB_STAT_OFS        4'h4

// Control register fields
`define TWB_CTRL_CONT_BIT   0
`define TWB_CTRL_CHKRD_BIT  1
`define TWB_CTRL_WRUSE_BIT  2
`define TWB_CTRL_RDUSE_BIT  3
`define TWB_CTRL_RST        4'h0

// Status register fields
`define TWB_STAT_REQ_BIT    0
`define TWB_STAT_DRV_BIT    1
`define TWB_STAT_AVL_BIT    2
`define TWB_STAT_OVF_BIT    3
`define TWB_STAT_WCE_BIT    4
`define TWB_STAT_CNT_LSB    8

////////////////////////////////////////////////////////////////////////////////
// Word counter codes, four count flags
`define TWB_CODE_TEN        4'h0
`define TWB_CODE_1          4'h1
`define TWB_CODE_2          4'h3
`define TWB_CODE_3          4'h2
`define TWB_CODE_4          4'h6
`define TWB_CODE_5          4'h7
`define TWB_CODE_6          4'h5
`define TWB_CODE_7          4'h4
`define TWB_CODE_8          4'hc
`define TWB_CODE_9          4'hd
`define TWB_CHK_RST         1'b1

////////////////////////////////////////////////////////////////////////////////
// Timing
`define TWB_CLK_PERIOD_NS   8
`define TWB_CHK_STEP_NS     1000
`define TWB_CHK_STEP_CYC    ((`TWB_CHK_STEP_NS + `TWB_CLK_PERIOD_NS - 1) / `TWB_CLK_PERIOD_NS)

`endif

//--- rtl/twb_ctrl.v
// Purpose: Word buffer, memory request and word counter control
// Assumes: All pulse inputs are one clock wide and synchronous to clk_i
// Notes:   Registers over classic Wishbone; no interrupt logic
//
// Added by the designer: the register offsets and the Wishbone register port.

`timescale 1ns/1ps
`include "twb_defs.vh"

module twb_ctrl
(
    // Clock and reset
    input  wire        clk_i,
    input  wire        arst_n_i,

    // Wishbone slave
    input  wire        wb_cyc_i,
    input  wire        wb_stb_i,
    input  wire        wb_we_i,
    input  wire [3:0]  wb_adr_i,
    input  wire [3:0]  wb_sel_i,
    input  wire [31:0] wb_dat_i,
    output reg  [31:0] wb_dat_o,
    output reg         wb_ack_o,

    // Synchronizer events
    input  wire        word_end_pulse_i,
    input  wire        first_load_pulse_i,
    input  wire        second_load_pulse_i,
    input  wire        operation_clear_pulse_i,
    input  wire        op_start_pulse_i,
    input  wire        op_end_pulse_i,

    // Dispatcher side
    input  wire        dispatcher_grant_i,
    input  wire        transfer_strobe_i,
    output reg         mem_request_o,
    output reg         word_driver_o,

    // Word count decodes
    output reg         count_is_one_o,
    output reg         count_is_two_o,
    output reg         count_is_three_o,
    output reg         count_is_seven_o,
    output reg         count_is_eight_o,
    output reg         count_is_nine_o,
    output reg         count_is_ten_o,

    // Status and errors
    output reg         circuits_available_o,
    output reg         overflow_error_pulse_o,
    output reg         counter_parity_error_o
);

////////////////////////////////////////////////////////////////////////////////
// Step decoder and count decoder

function [3:0] twb_next_code;
    input [3:0] code;
    begin
        case (code)
            `TWB_CODE_TEN: twb_next_code = `TWB_CODE_1;
            `TWB_CODE_1:   twb_next_code = `TWB_CODE_2;
            `TWB_CODE_2:   twb_next_code = `TWB_CODE_3;
            `TWB_CODE_3:   twb_next_code = `TWB_CODE_4;
            `TWB_CODE_4:   twb_next_code = `TWB_CODE_5;
            `TWB_CODE_5:   twb_next_code = `TWB_CODE_6;
            `TWB_CODE_6:   twb_next_code = `TWB_CODE_7;
            `TWB_CODE_7:   twb_next_code = `TWB_CODE_8;
            `TWB_CODE_8:   twb_next_code = `TWB_CODE_9;
            `TWB_CODE_9:   twb_next_code = `TWB_CODE_TEN;
            // Illegal codes fall back to ten; parity check flags them
            default:       twb_next_code = `TWB_CODE_TEN;
        endcase
    end
endfunction

// Bit order: ten, nine, eight, seven, three, two, one
function [6:0] twb_decode;
    input [3:0] code;
    begin
        case (code)
            `TWB_CODE_1:   twb_decode = 7'h01;
            `TWB_CODE_2:   twb_decode = 7'h02;
            `TWB_CODE_3:   twb_decode = 7'h04;
            `TWB_CODE_7:   twb_decode = 7'h08;
            `TWB_CODE_8:   twb_decode = 7'h10;
            `TWB_CODE_9:   twb_decode = 7'h20;
            `TWB_CODE_TEN: twb_decode = 7'h40;
            default:       twb_decode = 7'h00;
        endcase
    end
endfunction

////////////////////////////////////////////////////////////////////////////////
// State

localparam integer STEP_CYC_INT = `TWB_CHK_STEP_CYC;
localparam [6:0]   STEP_CYC     = STEP_CYC_INT[6:0];
reg  [3:0] ctrl_q;
reg  [3:0] ctrl_d;
reg        req_q;
reg        req_d;
reg        drv_q;
reg        drv_d;
reg  [3:0] cnt_q;
reg  [3:0] cnt_d;
reg        chk_q;
reg        chk_d;
reg        xfer_q;
reg        xfer_d;
reg        avl_q;
reg        avl_d;
reg        ovf_q;
reg        ovf_d;
reg        wce_q;
reg        wce_d;
reg  [6:0] dly_q;
reg  [6:0] dly_d;
reg        ack_d;
reg [31:0] rdat_d;

wire       cont_w;
wire       chkrd_w;
wire       wruse_w;
wire       rduse_w;
wire       bus_req_w;
wire       wr_w;
wire       ovf_ev_w;
wire       wce_ev_w;
wire       dly_fire_w;
wire       step_w;
wire       block_w;
wire       set_req_w;
wire [6:0] dec_w;

assign cont_w  = ctrl_q[`TWB_CTRL_CONT_BIT];
assign chkrd_w = ctrl_q[`TWB_CTRL_CHKRD_BIT];
assign wruse_w = ctrl_q[`TWB_CTRL_WRUSE_BIT];
assign rduse_w = ctrl_q[`TWB_CTRL_RDUSE_BIT];

assign bus_req_w = wb_cyc_i & wb_stb_i & ~wb_ack_o;
assign wr_w      = bus_req_w & wb_we_i & wb_sel_i[0];

////////////////////////////////////////////////////////////////////////////////
// Memory request

// Count decode taken at the word end itself, not continuously
assign block_w = ~cont_w & xfer_q & (cnt_q == `TWB_CODE_TEN);

assign set_req_w = (word_end_pulse_i & wruse_w & ~block_w)
                 | (word_end_pulse_i & rduse_w & ~chkrd_w)
                 | first_load_pulse_i
                 | second_load_pulse_i;

// Word end tests the flag before it is set again
assign ovf_ev_w = word_end_pulse_i & req_q;

always @*
begin
    // Set beats a grant in the same cycle
    req_d = set_req_w | (req_q & ~dispatcher_grant_i);
end

////////////////////////////////////////////////////////////////////////////////
// Word driver

always @*
begin
    drv_d = drv_q;
    if (first_load_pulse_i)
    begin
        drv_d = 1'b0;
    end
    else if (second_load_pulse_i)
    begin
        drv_d = 1'b1;
    end
    else if (operation_clear_pulse_i)
    begin
        drv_d = 1'b1;
    end
    else if (word_end_pulse_i)
    begin
        drv_d = ~drv_q;
    end
end

////////////////////////////////////////////////////////////////////////////////
// Word counter

// Check-read step is deferred so the count settles after the word end
assign dly_fire_w = (dly_q == 7'h01);
assign step_w     = chkrd_w ? dly_fire_w
                            : transfer_strobe_i;

always @*
begin
    dly_d = dly_q;
    if (op_start_pulse_i)
    begin
        dly_d = 7'h00;
    end
    else if (chkrd_w & word_end_pulse_i)
    begin
        dly_d = STEP_CYC;
    end
    else if (dly_q != 7'h00)
    begin
        dly_d = dly_q - 7'h01;
    end
end

always @*
begin
    cnt_d = cnt_q;
    chk_d = chk_q;
    if (op_start_pulse_i)
    begin
        cnt_d = `TWB_CODE_TEN;
        chk_d = `TWB_CHK_RST;
    end
    else if (step_w)
    begin
        cnt_d = twb_next_code(cnt_q);
        chk_d = ~chk_q;
    end
end

// Set by a transfer; held at ten so both closing word ends see it
always @*
begin
    xfer_d = xfer_q;
    if (op_start_pulse_i)
    begin
        xfer_d = 1'b0;
    end
    else if (step_w)
    begin
        xfer_d = 1'b1;
    end
    else if (word_end_pulse_i & (cnt_q != `TWB_CODE_TEN))
    begin
        xfer_d = 1'b0;
    end
end

assign dec_w = twb_decode(cnt_d);

////////////////////////////////////////////////////////////////////////////////
// Availability and checkers

always @*
begin
    avl_d = avl_q;
    if (op_start_pulse_i)
    begin
        avl_d = 1'b0;
    end
    else if (op_end_pulse_i)
    begin
        avl_d = 1'b1;
    end
end

// Level while the code is bad during an operation; masked while circuits are available
assign wce_ev_w = ~avl_q & ~(^{cnt_q, chk_q});

always @*
begin
    // Write one clears; a new event wins over the clear
    ovf_d = ovf_ev_w | (ovf_q & ~(wr_w & (wb_adr_i == `TWB_STAT_OFS)
                                  & wb_dat_i[`TWB_STAT_OVF_BIT]));
    wce_d = wce_ev_w | (wce_q & ~(wr_w & (wb_adr_i == `TWB_STAT_OFS)
                                  & wb_dat_i[`TWB_STAT_WCE_BIT]));
end

////////////////////////////////////////////////////////////////////////////////
// Register port

always @*
begin
    ctrl_d = ctrl_q;
    if (wr_w & (wb_adr_i == `TWB_CTRL_OFS))
    begin
        ctrl_d = wb_dat_i[3:0];
    end
end

always @*
begin
    ack_d  = bus_req_w;
    rdat_d = 32'h0000_0000;
    if (bus_req_w & ~wb_we_i)
    begin
        case (wb_adr_i)
            `TWB_CTRL_OFS:
            begin
                rdat_d[3:0] = ctrl_q;
            end
            `TWB_STAT_OFS:
            begin
                rdat_d[`TWB_STAT_REQ_BIT] = req_q;
                rdat_d[`TWB_STAT_DRV_BIT] = drv_q;
                rdat_d[`TWB_STAT_AVL_BIT] = avl_q;
                rdat_d[`TWB_STAT_OVF_BIT] = ovf_q;
                rdat_d[`TWB_STAT_WCE_BIT] = wce_q;
                rdat_d[`TWB_STAT_CNT_LSB +: 5] = {chk_q, cnt_q};
            end
            // Unmapped words read zero and still acknowledge
            default:
            begin
                rdat_d = 32'h0000_0000;
            end
        endcase
    end
end

////////////////////////////////////////////////////////////////////////////////
// Flip-flops

always @(posedge clk_i or negedge arst_n_i)
begin
    if (!arst_n_i)
    begin
        ctrl_q                 <= `TWB_CTRL_RST;
        req_q                  <= 1'b0;
        drv_q                  <= 1'b1;
        cnt_q                  <= `TWB_CODE_TEN;
        chk_q                  <= `TWB_CHK_RST;
        xfer_q                 <= 1'b0;
        avl_q                  <= 1'b1;
        ovf_q                  <= 1'b0;
        wce_q                  <= 1'b0;
        dly_q                  <= 7'h00;
        wb_ack_o               <= 1'b0;
        wb_dat_o               <= 32'h0000_0000;
        mem_request_o          <= 1'b0;
        word_driver_o          <= 1'b1;
        count_is_one_o         <= 1'b0;
        count_is_two_o         <= 1'b0;
        count_is_three_o       <= 1'b0;
        count_is_seven_o       <= 1'b0;
        count_is_eight_o       <= 1'b0;
        count_is_nine_o        <= 1'b0;
        count_is_ten_o         <= 1'b1;
        circuits_available_o   <= 1'b1;
        overflow_error_pulse_o <= 1'b0;
        counter_parity_error_o <= 1'b0;
    end
    else
    begin
        ctrl_q                 <= ctrl_d;
        req_q                  <= req_d;
        drv_q                  <= drv_d;
        cnt_q                  <= cnt_d;
        chk_q                  <= chk_d;
        xfer_q                 <= xfer_d;
        avl_q                  <= avl_d;
        ovf_q                  <= ovf_d;
        wce_q                  <= wce_d;
        dly_q                  <= dly_d;
        wb_ack_o               <= ack_d;
        wb_dat_o               <= rdat_d;
        mem_request_o          <= req_d;
        // One select bit steers all four buffers
        word_driver_o          <= drv_d;
        count_is_one_o         <= dec_w[0];
        count_is_two_o         <= dec_w[1];
        count_is_three_o       <= dec_w[2];
        count_is_seven_o       <= dec_w[3];
        count_is_eight_o       <= dec_w[4];
        count_is_nine_o        <= dec_w[5];
        count_is_ten_o         <= dec_w[6];
        circuits_available_o   <= avl_d;
        overflow_error_pulse_o <= ovf_ev_w;
        counter_parity_error_o <= wce_ev_w;
    end
end

endmodule

//--- verification/twb_ctrl_chk.sv
// Purpose: Port assertions for word buffer control
// Assumes: One clock, pulse inputs one cycle wide
// Notes:   Set beats grant, so clears are checked without a set
`timescale 1ns/1ps
module twb_ctrl_chk
(
    // Clock and reset
    input logic clk_i,
    input logic arst_n_i,
    // Watched ports
    input logic wb_ack_o,
    input logic word_end_pulse_i,
    input logic first_load_pulse_i,
    input logic second_load_pulse_i,
    input logic operation_clear_pulse_i,
    input logic op_start_pulse_i,
    input logic op_end_pulse_i,
    input logic dispatcher_grant_i,
    input logic transfer_strobe_i,
    input logic mem_request_o,
    input logic word_driver_o,
    input logic count_is_ten_o,
    input logic circuits_available_o,
    input logic overflow_error_pulse_o,
    input logic counter_parity_error_o
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!arst_n_i);
    wire ld = first_load_pulse_i | second_load_pulse_i;
    wire we = word_end_pulse_i;
    ////////////////////////////////////////////////////////////
    AST_REQ_HOLD: assert property (mem_request_o && !dispatcher_grant_i |=> mem_request_o)
        else $error("request lost");
    AST_GRANT_CLR: assert property (dispatcher_grant_i && !we && !ld |=> !mem_request_o)
        else $error("grant ignored");
    AST_FIRST_LD: assert property (first_load_pulse_i |=> mem_request_o && !word_driver_o)
        else $error("first load");
    AST_SECOND_LD: assert property (second_load_pulse_i && !first_load_pulse_i
        |=> mem_request_o && word_driver_o) else $error("second load");
    AST_DRV_TGL: assert property (we && !ld && !operation_clear_pulse_i
        |=> word_driver_o != $past(word_driver_o)) else $error("no toggle");
    AST_OP_CLR: assert property (operation_clear_pulse_i && !ld |=> word_driver_o)
        else $error("op clear");
    AST_OVF_SET: assert property (we && mem_request_o |=> overflow_error_pulse_o)
        else $error("overflow missed");
    AST_OVF_WHY: assert property (overflow_error_pulse_o
        |-> $past(word_end_pulse_i) && $past(mem_request_o)) else $error("stray overflow");
    AST_START: assert property (op_start_pulse_i && !transfer_strobe_i && !op_end_pulse_i
        |=> count_is_ten_o && !circuits_available_o) else $error("start");
    AST_END: assert property (op_end_pulse_i |=> circuits_available_o)
        else $error("end");
    AST_PAR_OFF: assert property (circuits_available_o [*2] |-> !counter_parity_error_o)
        else $error("parity while idle");
    AST_ACK: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack too long");
    cover property (overflow_error_pulse_o);
    cover property (dispatcher_grant_i && transfer_strobe_i);
    cover property ($rose(count_is_ten_o));
endmodule
bind twb_ctrl twb_ctrl_chk i_twb_ctrl_chk (.clk_i, .arst_n_i, .wb_ack_o, .word_end_pulse_i,
    .first_load_pulse_i, .second_load_pulse_i, .operation_clear_pulse_i, .op_start_pulse_i,
    .op_end_pulse_i, .dispatcher_grant_i, .transfer_strobe_i, .mem_request_o, .word_driver_o,
    .count_is_ten_o, .circuits_available_o, .overflow_error_pulse_o, .counter_parity_error_o);

//--- verification/twb_dispatcher_model.sv
// Purpose: Memory dispatcher stand-in
// Assumes: Grant and strobe share one edge
// Notes:   Stall holds grants off to force overflow
`timescale 1ns/1ps
module twb_dispatcher_model
(
    // Clock and reset
    input  logic clk_i,
    input  logic arst_n_i,
    // Block side
    input  logic mem_request_i,
    input  logic stall_i,
    output logic grant_o,
    output logic strobe_o
);
    logic [1:0] wait_q;
    always @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            wait_q   <= 2'h0;
            grant_o  <= 1'b0;
            strobe_o <= 1'b0;
        end
        else
        begin
            grant_o  <= 1'b0;
            strobe_o <= 1'b0;
            // Skip the edge after a grant: request is still high there
            if (!mem_request_i || grant_o || stall_i)
                wait_q <= 2'h0;
            else if (wait_q == 2'h3)
            begin
                grant_o  <= 1'b1;
                strobe_o <= 1'b1;
                wait_q   <= 2'h0;
            end
            else
                wait_q <= wait_q + 2'h1;
        end
    end
endmodule

//--- verification/test_twb_ctrl.sv
// Purpose: Self-checking bench for word buffer control
// Assumes: Dispatcher model grants four cycles after a request
// Notes:   Checks sit on falling edges, after updates settle
`timescale 1ns/1ps
module test_twb_ctrl;
    localparam logic [5:0] WE = 6'h01, FL = 6'h02, SL = 6'h04;
    localparam logic [5:0] OC = 6'h08, ST = 6'h10, EN = 6'h20;
    logic        clk_i = 1'b0;
    logic        arst_n_i = 1'b0;
    logic        cyc = 1'b0;
    logic        stb = 1'b0;
    logic        we = 1'b0;
    logic [3:0]  adr = 4'h0;
    logic [31:0] wdat = 32'h0;
    logic [5:0]  ev = 6'h00;
    logic        stall = 1'b0;
    logic [31:0] rdat, v;
    logic        ack, req, drv, gnt, stp, avl, ovf, perr, d;
    logic [6:0]  dec;
    int          miscompares = 0;
    int          samples_checked = 0;
    int          c;
    always #4 clk_i = ~clk_i;
    twb_ctrl i_twb_ctrl (.clk_i, .arst_n_i, .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .word_end_pulse_i(ev[0]), .first_load_pulse_i(ev[1]), .second_load_pulse_i(ev[2]),
        .operation_clear_pulse_i(ev[3]), .op_start_pulse_i(ev[4]), .op_end_pulse_i(ev[5]),
        .dispatcher_grant_i(gnt), .transfer_strobe_i(stp), .mem_request_o(req),
        .word_driver_o(drv), .count_is_one_o(dec[6]), .count_is_two_o(dec[5]),
        .count_is_three_o(dec[4]), .count_is_seven_o(dec[3]), .count_is_eight_o(dec[2]),
        .count_is_nine_o(dec[1]), .count_is_ten_o(dec[0]), .circuits_available_o(avl),
        .overflow_error_pulse_o(ovf), .counter_parity_error_o(perr));
    twb_dispatcher_model i_twb_dispatcher_model (.clk_i, .arst_n_i, .mem_request_i(req),
        .stall_i(stall), .grant_o(gnt), .strobe_o(stp));
    ////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        samples_checked++;
        if (g !== e)
        begin
            miscompares++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] dw,
        output logic [31:0] dr);
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= dw;
        do
        begin
            @(posedge clk_i);
        end
        while (ack !== 1'b1);
        dr = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
        @(negedge clk_i);
        chk(ack, 1'b0);
    endtask
    task automatic pulse(input logic [5:0] p);
        @(posedge clk_i);
        ev <= p;
        @(posedge clk_i);
        ev <= 6'h00;
        @(negedge clk_i);
    endtask
    task automatic idle();
        int n = 0;
        while (req === 1'b1 && n < 64)
        begin
            @(negedge clk_i);
            n++;
        end
        chk(req, 1'b0);
    endtask
    function automatic logic [6:0] xd(input int n);
        case (n)
            1: xd = 7'h40;
            2: xd = 7'h20;
            3: xd = 7'h10;
            7: xd = 7'h08;
            8: xd = 7'h04;
            9: xd = 7'h02;
            10: xd = 7'h01;
            default: xd = 7'h00;
        endcase
    endfunction
    task automatic test_done();
        $display("checks=%0d mismatches=%0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////
    initial
    begin
        repeat (16) @(posedge clk_i);
        arst_n_i <= 1'b1;
        @(negedge clk_i);
        chk({dec, drv, req, avl}, {7'h01, 3'b101});
        wb(0, 4'h4, 0, v); chk(v, 32'h1006);
        wb(1, 4'h0, 32'h5, v);
        wb(0, 4'h0, 0, v); chk(v, 32'h5);
        wb(0, 4'h8, 0, v); chk(v, 32'h0);
        pulse(ST); chk({dec, avl}, {7'h01, 1'b0});
        pulse(FL); chk({drv, req}, 2'b01);
        idle(); chk(dec, xd(1));
        pulse(SL); chk({drv, req}, 2'b11);
        idle(); chk(dec, xd(2));
        for (c = 3; c <= 10; c++)
        begin
            d = drv;
            pulse(WE); chk({drv, req}, {~d, 1'b1});
            idle(); chk(dec, xd(c));
        end
        wb(0, 4'h4, 0, v); chk(v[12:8], 5'h10);
        wb(1, 4'h0, 32'h4, v);
        repeat (2)
        begin
            pulse(WE); chk({req, dec}, {1'b0, 7'h01});
        end
        pulse(EN); chk(avl, 1'b1);
        // Read operation with the dispatcher stalled
        wb(1, 4'h0, 32'h9, v);
        pulse(ST);
        stall = 1'b1;
        pulse(WE); chk(req, 1'b1);
        pulse(WE); chk(ovf, 1'b1);
        wb(0, 4'h4, 0, v); chk(v[3], 1'b1);
        wb(1, 4'h4, 32'h8, v);
        wb(0, 4'h4, 0, v); chk(v[3], 1'b0);
        stall = 1'b0;
        idle(); chk(dec, xd(1));
        if (drv === 1'b1)
        begin
            pulse(WE);
            idle();
        end
        pulse(OC); chk(drv, 1'b1);
        pulse(EN);
        // Check-read: word end steps the count after a delay
        wb(1, 4'h0, 32'ha, v);
        pulse(ST);
        pulse(WE); chk(req, 1'b0);
        repeat (120) @(negedge clk_i);
        chk(dec, xd(10));
        repeat (10) @(negedge clk_i);
        chk(dec, xd(1));
        chk(perr, 1'b0);
        test_done();
    end
    initial
    begin
        #200000;
        miscompares++;
        test_done();
    end
endmodule
